// >>> rtl/dshc_top.sv
// drive status and head control: head load, door lock, led, track zero,
// write protect, index gating, ready detector, side select
// assumes pin inputs are asynchronous; registers reached over classic wishbone
//
// How it works
// - solenoid on only with request and speed
// - 20 ms pull-in drive then holding drive
// - release when request or speed drops
// - lock and led drivers need speed
// - led follows head load or lock, configurable
// - lock on head load, io gate, lock request
// - home output needs switch, phases A,C, gate
// - wrong phase drops home until three steps
// - media lock from notch and jumper choice
// - media lock blocks internal write permission
// - guard output only while output gate high
// - unprotected disk: guard inactive, writes allowed
// - index forwarded when io gate; always to ready
// - gap over 300 ms clears index counter
// - closer pulses keep timer and counter running
// - three pulses raise speed and ready
// - side input picks exactly one head
// - step pulses blocked during write or media lock
// - 40 ms power-up pulse clears ready, erase
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module dshc_top
  import dshc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic head_load_request_i,
  input wire logic drive_io_gate_i,
  input wire logic latch_lock_request_i,
  input wire logic output_gate_i,
  input wire logic host_write_gate_n_i,
  input wire logic host_step_i,
  input wire logic side_i,
  input wire logic home_switch_i,
  input wire logic phase_a_i,
  input wire logic phase_c_i,
  input wire logic notch_open_i,
  input wire logic index_sense_i,
  input wire logic power_up_clear_n_i,
  output logic solenoid_on_o,
  output logic solenoid_pullin_o,
  output logic door_lock_o,
  output logic activity_led_o,
  output logic home_track_n_o,
  output logic media_guard_n_o,
  output logic write_permit_o,
  output logic step_out_o,
  output logic index_n_o,
  output logic ready_n_o,
  output logic head0_en_o,
  output logic head1_en_o,
  output logic erase_clear_o
);
  localparam int NIN = 14;
  logic [NIN-1:0] raw, s1_reg, s2_reg;
  assign raw = {power_up_clear_n_i, index_sense_i, notch_open_i, phase_c_i, phase_a_i,
                home_switch_i, side_i, host_step_i, host_write_gate_n_i, output_gate_i,
                latch_lock_request_i, drive_io_gate_i, head_load_request_i, 1'b0};
  // two-stage synchronisers; nothing reads s1_reg but s2_reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  logic hl_req, io_gate, lock_req, out_gate, wgate_n, step, side, home_sw, ph_a, ph_c;
  logic notch_open, idx, pu_n;
  assign {pu_n, idx, notch_open, ph_c, ph_a, home_sw, side, step, wgate_n, out_gate,
          lock_req, io_gate, hl_req} = s2_reg[NIN-1:1];

  // wishbone registers
  logic [3:0] ctrl_reg, ctrl_next;
  logic ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic speed_reg;
  logic hl_on;
  dshc_hl_t hl_reg, hl_next;
  logic [1:0] ph_reg;
  logic media_locked;
  logic home_ok;
  logic init_act;
  logic [31:0] stat_word;
  assign stat_word = {24'h000000, home_ok, media_locked, ph_reg, hl_on, hl_reg == DSHC_HL_PULL,
                      speed_reg, init_act};
  always_comb begin
    ctrl_next = ctrl_reg;
    ack_next = 1'b0;
    rd_next = rd_reg;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      ack_next = 1'b1;
      rd_next = 32'h00000000;
      if (wb_adr_i == WB_OFS_CTRL) begin
        rd_next = {28'h0000000, ctrl_reg};
      end else if (wb_adr_i == WB_OFS_STAT) begin
        rd_next = stat_word;
      end
    end
    // the write lands on the edge at which the master sees ack high
    if (wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == WB_OFS_CTRL) begin
      ctrl_next = wb_dat_i[3:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      ack_reg <= 1'b0;
      rd_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  // power-up clear: sync reset or a low clear pin starts a 40 ms pulse
  logic [CNT_W-1:0] init_cnt_reg, init_cnt_next;
  always_comb begin
    init_cnt_next = init_cnt_reg;
    if (!pu_n) begin
      init_cnt_next = CNT_W'(INIT_CYC);
    end else if (init_cnt_reg != CNT_ZERO) begin
      init_cnt_next = init_cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt_reg <= CNT_W'(INIT_CYC);
    end else begin
      init_cnt_reg <= init_cnt_next;
    end
  end
  assign init_act = init_cnt_reg != CNT_ZERO;

  // ready detector: retriggerable holdover and index counter
  logic idx_d_reg, idx_rise;
  logic [CNT_W-1:0] hold_reg, hold_next;
  logic [1:0] icnt_reg, icnt_next;
  logic speed_next;
  assign idx_rise = idx && !idx_d_reg;
  always_comb begin
    hold_next = hold_reg;
    icnt_next = icnt_reg;
    if (idx_rise) begin
      hold_next = CNT_W'(HOLDOVER_CYC);
      if (hold_reg != CNT_ZERO && icnt_reg != IDX_READY_CNT) begin
        icnt_next = icnt_reg + 2'h1;
      end else if (hold_reg == CNT_ZERO) begin
        icnt_next = 2'h1;
      end
    end else if (hold_reg != CNT_ZERO) begin
      hold_next = hold_reg - 1'b1;
    end else begin
      icnt_next = 2'h0;
    end
    if (init_act) begin
      hold_next = CNT_ZERO;
      icnt_next = 2'h0;
    end
    speed_next = icnt_next == IDX_READY_CNT;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_d_reg <= 1'b0;
      hold_reg <= CNT_ZERO;
      icnt_reg <= 2'h0;
      speed_reg <= 1'b0;
    end else begin
      idx_d_reg <= idx;
      hold_reg <= hold_next;
      icnt_reg <= icnt_next;
      speed_reg <= speed_next;
    end
  end

  // head load solenoid with pull-in one-shot
  logic [CNT_W-1:0] pull_reg, pull_next;
  always_comb begin
    hl_next = hl_reg;
    pull_next = pull_reg;
    unique case (hl_reg)
      DSHC_HL_OFF: begin
        if (hl_req && speed_reg) begin
          hl_next = DSHC_HL_PULL;
          pull_next = CNT_W'(PULLIN_CYC - 1);
        end
      end
      DSHC_HL_PULL: begin
        if (pull_reg == CNT_ZERO) begin
          hl_next = DSHC_HL_HOLD;
        end else begin
          pull_next = pull_reg - 1'b1;
        end
      end
      DSHC_HL_HOLD: ;
      default: hl_next = DSHC_HL_OFF;
    endcase
    if (!(hl_req && speed_reg)) begin
      hl_next = DSHC_HL_OFF;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hl_reg <= DSHC_HL_OFF;
      pull_reg <= CNT_ZERO;
    end else begin
      hl_reg <= hl_next;
      pull_reg <= pull_next;
    end
  end
  assign hl_on = hl_reg != DSHC_HL_OFF;
  // counts how long the pull-in drive has stood, for the length check below
  logic [CNT_W-1:0] pin_cnt_reg, pin_cnt_next;
  always_comb begin
    pin_cnt_next = solenoid_pullin_o ? pin_cnt_reg + 1'b1 : CNT_ZERO;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_cnt_reg <= CNT_ZERO;
    end else begin
      pin_cnt_reg <= pin_cnt_next;
    end
  end

  // stepper phase tracking for home qualification; counts out-steps mod 4
  logic step_d_reg, step_fall;
  logic [1:0] ph_next;
  assign step_fall = step_d_reg && !step;
  always_comb begin
    ph_next = ph_reg;
    if (!ph_a || !ph_c) begin
      ph_next = ph_reg;
    end
    if (step_fall && home_sw && step_out_o) begin
      ph_next = ph_reg + 2'h1;
    end
    if (!home_sw) begin
      ph_next = PH_INIT;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_d_reg <= 1'b0;
      ph_reg <= PH_INIT;
    end else begin
      step_d_reg <= step;
      ph_reg <= ph_next;
    end
  end
  // phase inputs reflect A and C energised; the counter only guards overrun
  assign home_ok = home_sw && ph_a && ph_c && ph_reg == PH_FWD_OK;

  // write protect: jumper choice in ctrl bit selects which notch state protects
  assign media_locked = ctrl_reg[CTRL_PROT_OPEN] ? notch_open : !notch_open;

  logic lock_next, led_next, home_n_next, guard_n_next, wp_next, step_next;
  logic idx_n_next, h0_next, h1_next;
  always_comb begin
    lock_next = speed_reg && (hl_req || io_gate || lock_req || ctrl_reg[CTRL_SW_LOCK]);
    led_next = speed_reg && (ctrl_reg[CTRL_LED_LOCK] ? lock_next : hl_on);
    home_n_next = !(home_ok && out_gate);
    guard_n_next = !(media_locked && out_gate);
    wp_next = !wgate_n && !media_locked;
    step_next = step && wgate_n && !media_locked;
    idx_n_next = !(idx && io_gate);
    h0_next = !(side ^ ctrl_reg[CTRL_SW_SIDE]);
    h1_next = side ^ ctrl_reg[CTRL_SW_SIDE];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      solenoid_on_o <= 1'b0;
      solenoid_pullin_o <= 1'b0;
      door_lock_o <= 1'b0;
      activity_led_o <= 1'b0;
      home_track_n_o <= 1'b1;
      media_guard_n_o <= 1'b1;
      write_permit_o <= 1'b0;
      step_out_o <= 1'b0;
      index_n_o <= 1'b1;
      ready_n_o <= 1'b1;
      head0_en_o <= 1'b1;
      head1_en_o <= 1'b0;
      erase_clear_o <= 1'b1;
    end else begin
      solenoid_on_o <= hl_next != DSHC_HL_OFF;
      solenoid_pullin_o <= hl_next == DSHC_HL_PULL;
      door_lock_o <= lock_next;
      activity_led_o <= led_next;
      home_track_n_o <= home_n_next;
      media_guard_n_o <= guard_n_next;
      write_permit_o <= wp_next;
      step_out_o <= step_next;
      index_n_o <= idx_n_next;
      ready_n_o <= !speed_next;
      head0_en_o <= h0_next;
      head1_en_o <= h1_next;
      erase_clear_o <= init_act;
    end
  end

  // checks
  hl_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    solenoid_on_o |-> $past(hl_req && speed_reg))
    else $error("solenoid on without request and speed");
  pullin_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(solenoid_pullin_o) && solenoid_on_o |-> pin_cnt_reg == CNT_W'(PULLIN_CYC))
    else $error("pull-in length wrong");
  hl_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(hl_req && speed_reg) |=> !solenoid_on_o)
    else $error("solenoid not released");
  lock_speed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (door_lock_o || activity_led_o) |-> $past(speed_reg))
    else $error("driver on without speed");
  guard_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !media_guard_n_o |-> $past(out_gate && media_locked))
    else $error("guard driven without gate");
  wp_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    media_locked |=> !write_permit_o)
    else $error("write permitted on locked media");
  index_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !index_n_o |-> $past(io_gate && idx))
    else $error("index passed without io gate");
  heads_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    head0_en_o != head1_en_o)
    else $error("head enables not exclusive");
  ready_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ready_n_o |-> speed_reg)
    else $error("ready without speed");
  step_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wgate_n |=> !step_out_o)
    else $error("step passed during write");
  cov_hold_c: cover property (@(posedge clk_i) hl_reg == DSHC_HL_HOLD);
  cov_ready_c: cover property (@(posedge clk_i) $fell(ready_n_o));
  cov_home_c: cover property (@(posedge clk_i) $fell(home_track_n_o));
  cov_guard_c: cover property (@(posedge clk_i) $fell(media_guard_n_o));
endmodule

// >>> rtl/dshc_pkg.sv
// constants for the drive status and head control block
// assumes a 50 MHz local clock; all times are converted to cycle counts here
package dshc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PULLIN_MS = 20;
  localparam int unsigned HOLDOVER_MS = 300;
  localparam int unsigned INIT_MS = 40;
  localparam int unsigned PULLIN_CYC = PULLIN_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLDOVER_CYC = HOLDOVER_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_CYC = INIT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 24;
  localparam logic [1:0] IDX_READY_CNT = 2'h3;
  localparam logic [1:0] PH_FWD_OK = 2'h0;
  localparam logic [1:0] PH_INIT = 2'h0;
  // synchroniser reset image: active-low pins (clear, write gate) sit at their idle high level
  localparam logic [13:0] SYNC_IDLE = 14'h2020;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [3:0] WB_OFS_CTRL = 4'h0;
  localparam logic [3:0] WB_OFS_STAT = 4'h4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int unsigned CTRL_LED_LOCK = 0;
  localparam int unsigned CTRL_PROT_OPEN = 1;
  localparam int unsigned CTRL_SW_LOCK = 2;
  localparam int unsigned CTRL_SW_SIDE = 3;
  typedef enum logic [1:0] {
    DSHC_HL_OFF = 2'b00,
    DSHC_HL_PULL = 2'b01,
    DSHC_HL_HOLD = 2'b10
  } dshc_hl_t;
endpackage

// >>> tb/dshc_host_model.sv
// host controller and stepper mechanism model for the drive status block
// assumes step_out_i is the block's gated step; the phases advance on its fall
`timescale 1ns/10ps
module dshc_host_model (
  input wire logic clk_i,
  input wire logic step_out_i,
  output logic host_step_o,
  output logic phase_a_o,
  output logic phase_c_o
);
  logic [1:0] ph_reg = 2'h0;
  logic step_d = 1'b0;
  initial host_step_o = 1'b0;
  // outward sequence: A and C, A only, neither, C only, then A and C again
  always @(posedge clk_i) begin
    step_d <= step_out_i;
    if (step_d && !step_out_i) begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  assign phase_a_o = (ph_reg == 2'h0) || (ph_reg == 2'h1);
  assign phase_c_o = (ph_reg == 2'h0) || (ph_reg == 2'h3);
  // pulses go out one at a time with idle gaps, so the synchroniser sees each edge
  task automatic step_once();
    @(posedge clk_i);
    host_step_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    host_step_o <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// >>> tb/dshc_top_tb_top.sv
// testbench for the drive status and head control block
// assumes the whole run stays inside the power-up pulse, so speed never rises
`timescale 1ns/10ps
module dshc_top_tb_top;
  import dshc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic hl_req = 1'b0, io_gate = 1'b0, lock_req = 1'b0, out_gate = 1'b0;
  logic wgate_n = 1'b1, side = 1'b0, home_sw = 1'b0, notch_open = 1'b0, index = 1'b0;
  logic pu_clr_n = 1'b1;
  logic host_step, ph_a, ph_c, sol_on, pullin, door, led, home_n, guard_n, wpermit;
  logic step_out, index_n, ready_n, head0, head1, erase_clr;
  logic [31:0] rd;
  logic step_d = 1'b0;
  int checks = 0;
  int mismatches = 0;
  int steps_seen = 0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  dshc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .head_load_request_i(hl_req),
    .drive_io_gate_i(io_gate), .latch_lock_request_i(lock_req), .output_gate_i(out_gate),
    .host_write_gate_n_i(wgate_n), .host_step_i(host_step), .side_i(side),
    .home_switch_i(home_sw), .phase_a_i(ph_a), .phase_c_i(ph_c), .notch_open_i(notch_open),
    .index_sense_i(index), .power_up_clear_n_i(pu_clr_n), .solenoid_on_o(sol_on),
    .solenoid_pullin_o(pullin), .door_lock_o(door), .activity_led_o(led),
    .home_track_n_o(home_n), .media_guard_n_o(guard_n), .write_permit_o(wpermit),
    .step_out_o(step_out), .index_n_o(index_n), .ready_n_o(ready_n), .head0_en_o(head0),
    .head1_en_o(head1), .erase_clear_o(erase_clr));
  dshc_host_model host (.clk_i(clk_i), .step_out_i(step_out), .host_step_o(host_step),
    .phase_a_o(ph_a), .phase_c_o(ph_c));
  always @(posedge clk_i) begin
    step_d <= step_out;
    if (step_out === 1'b1 && step_d !== 1'b1) begin
      steps_seen++;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pins pass a two-flop synchroniser, so give them time to land
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    if (n == 50) begin
      mismatches++;
      $display("CHECK FAILED bus ack expected 1 seen timeout");
      report_and_stop();
    end else begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    wb(1'b0, WB_OFS_CTRL, 32'h0, 4'hf, rd);
    chk("ctrl reset", 32'h0, rd);
    wb(1'b0, WB_OFS_STAT, 32'h0, 4'hf, rd);
    chk("init active", 32'h1, {31'h0, rd[0]});
    chk("erase clear", 32'h1, {31'h0, erase_clr});
    // a low clear pin restarts the power-up pulse, which must stay in force
    @(posedge clk_i);
    pu_clr_n <= 1'b0;
    settle();
    pu_clr_n <= 1'b1;
    settle();
    chk("erase clear again", 32'h1, {31'h0, erase_clr});
    wb(1'b0, WB_OFS_STAT, 32'h0, 4'hf, rd);
    chk("init again", 32'h1, {31'h0, rd[0]});
    // without speed the solenoid, lock and led stay dark whatever is requested
    @(posedge clk_i);
    hl_req <= 1'b1;
    io_gate <= 1'b1;
    lock_req <= 1'b1;
    settle();
    chk("solenoid", 32'h0, {30'h0, sol_on, pullin});
    chk("lock and led", 32'h0, {30'h0, door, led});
    chk("ready", 32'h1, {31'h0, ready_n});
    @(posedge clk_i);
    index <= 1'b1;
    settle();
    chk("index gated on", 32'h0, {31'h0, index_n});
    @(posedge clk_i);
    io_gate <= 1'b0;
    settle();
    chk("index gated off", 32'h1, {31'h0, index_n});
    @(posedge clk_i);
    index <= 1'b0;
    hl_req <= 1'b0;
    out_gate <= 1'b1;
    home_sw <= 1'b1;
    notch_open <= 1'b1;
    settle();
    chk("home", 32'h0, {31'h0, home_n});
    chk("guard open notch", 32'h1, {31'h0, guard_n});
    host.step_once();
    settle();
    chk("home wrong phase", 32'h1, {31'h0, home_n});
    repeat (3) host.step_once();
    settle();
    chk("home restored", 32'h0, {31'h0, home_n});
    chk("steps passed", 32'h4, steps_seen);
    @(posedge clk_i);
    out_gate <= 1'b0;
    settle();
    chk("home gated", 32'h1, {31'h0, home_n});
    // protect a covered notch (reset choice), then an open one
    @(posedge clk_i);
    notch_open <= 1'b0;
    settle();
    chk("guard gated", 32'h1, {31'h0, guard_n});
    @(posedge clk_i);
    out_gate <= 1'b1;
    settle();
    chk("guard covered", 32'h0, {31'h0, guard_n});
    @(posedge clk_i);
    notch_open <= 1'b1;
    wb(1'b1, WB_OFS_CTRL, 32'h2, 4'h1, rd);
    wb(1'b1, WB_OFS_CTRL, 32'h0, 4'he, rd);
    wb(1'b1, 4'h8, 32'hf, 4'hf, rd);
    wb(1'b0, 4'h8, 32'h0, 4'hf, rd);
    chk("unmapped read", 32'h0, rd);
    wb(1'b0, WB_OFS_CTRL, 32'h0, 4'hf, rd);
    chk("ctrl after writes", 32'h2, {28'h0, rd[3:0]});
    @(posedge clk_i);
    wgate_n <= 1'b0;
    settle();
    chk("guard open protected", 32'h0, {31'h0, guard_n});
    chk("write permit", 32'h0, {31'h0, wpermit});
    host.step_once();
    wb(1'b1, WB_OFS_CTRL, 32'h0, 4'h1, rd);
    host.step_once();
    settle();
    chk("steps blocked", 32'h4, steps_seen);
    chk("guard unprotected", 32'h1, {31'h0, guard_n});
    chk("write permit open", 32'h1, {31'h0, wpermit});
    // software lock and led-follows-lock still need speed
    wb(1'b1, WB_OFS_CTRL, 32'h5, 4'h1, rd);
    settle();
    chk("sw lock no speed", 32'h0, {30'h0, door, led});
    // side select, then the same side inverted by control
    @(posedge clk_i);
    wgate_n <= 1'b1;
    side <= 1'b1;
    settle();
    chk("side one", 32'h1, {30'h0, head0, head1});
    wb(1'b1, WB_OFS_CTRL, 32'h8, 4'h1, rd);
    settle();
    chk("side inverted", 32'h2, {30'h0, head0, head1});
    @(posedge clk_i);
    side <= 1'b0;
    settle();
    chk("side zero inv", 32'h1, {30'h0, head0, head1});
    report_and_stop();
  end
endmodule
